// ### ssd_sram_port.sv
// Behaviour
// - Active-low byte write selects sampled on K and K#, one per byte lane.
// - Bytes whose select is high during a write beat stay unchanged.
// - Read address taken on K rise, write address on K# rise.
// - Address width 23/22/21 by word width; storage is two arrays.
// - Address ignored on edges belonging to a deselected port.
// - Read beats leave on C and C# rises; K and K# in single clock mode.
// - Read data outputs float once the read port is deselected and no read is pending.
// - Active-low read select sampled on K rise starts a read.
// - On read deselect, finish pending read, float after next C rise.
// - Every read returns exactly two sequential words.
// - Accesses start only on K rise; selects, read address and first write beat captured there.
// - Write address, second data beat and its selects captured on K#.
// - Free-running echo clocks follow C and C#.
// - In single clock mode echo clocks follow K and K#.
// - Active-low write select on K rise starts a write; else data ignored.
// - Write data beats sampled on K and K# rises during a write.
`timescale 1ns/10ps
`default_nettype none

module ssd_sram_port #(
  parameter int MEM_AW = ssd_pkg::MEM_AW,
  parameter int FIFO_DEPTH = ssd_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic k_clk_i,
  input wire logic k_n_clk_i,
  input wire logic c_clk_i,
  input wire logic c_n_clk_i,
  input wire logic read_port_sel_n_i,
  input wire logic write_port_sel_n_i,
  input wire logic [ssd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ssd_pkg::DATA_W-1:0] data_i,
  input wire logic [ssd_pkg::NUM_BYTES-1:0] byte_write_sel_n_i,
  output logic [ssd_pkg::DATA_W-1:0] q_o,
  output logic q_oe_n_o,
  output logic echo_clock_pos_o,
  output logic echo_clock_neg_o,
  output logic cmd_ready_o
);

  localparam int DW = ssd_pkg::DATA_W;
  localparam int NB = ssd_pkg::NUM_BYTES;
  localparam int BW = ssd_pkg::BYTE_W;
  localparam int CMD_W = $bits(ssd_pkg::ssd_cmd_t);
  localparam int RD_W = $bits(ssd_pkg::ssd_rdata_t);

  // Reset brought into each pin clock by two flip-flops
  logic k_rst_s1_reg, k_rst_n_reg;
  logic kn_rst_s1_reg, kn_rst_n_reg;
  logic c_rst_s1_reg, c_rst_n_reg;
  logic cn_rst_s1_reg, cn_rst_n_reg;

  always_ff @(posedge k_clk_i) begin
    k_rst_s1_reg <= resetn_i;
    k_rst_n_reg <= k_rst_s1_reg;
  end

  always_ff @(posedge k_n_clk_i) begin
    kn_rst_s1_reg <= resetn_i;
    kn_rst_n_reg <= kn_rst_s1_reg;
  end

  always_ff @(posedge c_clk_i) begin
    c_rst_s1_reg <= resetn_i;
    c_rst_n_reg <= c_rst_s1_reg;
  end

  always_ff @(posedge c_n_clk_i) begin
    cn_rst_s1_reg <= resetn_i;
    cn_rst_n_reg <= cn_rst_s1_reg;
  end

  // K rise: port selects, read address and first write beat
  logic k_rd_reg, k_wr_reg;
  logic [ssd_pkg::ADDR_W-1:0] k_raddr_reg;
  logic [DW-1:0] k_d0_reg;
  logic [NB-1:0] k_be0_n_reg;

  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n_reg) begin
      k_rd_reg <= ssd_pkg::RST_LOW;
      k_wr_reg <= ssd_pkg::RST_LOW;
    end else begin
      k_rd_reg <= !read_port_sel_n_i;
      k_wr_reg <= !write_port_sel_n_i;
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n_reg) begin
      k_raddr_reg <= '0;
    end else if (!read_port_sel_n_i) begin
      k_raddr_reg <= addr_i;
    end
  end

  always_ff @(posedge k_clk_i) begin
    if (!k_rst_n_reg) begin
      k_d0_reg <= '0;
      k_be0_n_reg <= '1;
    end else if (!write_port_sel_n_i) begin
      k_d0_reg <= data_i;
      k_be0_n_reg <= byte_write_sel_n_i;
    end
  end

  // K# rise: write address, second beat, then the whole access is queued.
  // K# is the complement of K, so the K registers are half a cycle old here.
  ssd_pkg::ssd_cmd_t cmd_reg, cmd_out;
  logic cmd_valid_reg, cmd_wready, cmd_rvalid, cmd_pop;

  always_ff @(posedge k_n_clk_i) begin
    if (!kn_rst_n_reg) begin
      cmd_valid_reg <= ssd_pkg::RST_LOW;
    end else begin
      cmd_valid_reg <= k_rd_reg || k_wr_reg;
    end
  end

  always_ff @(posedge k_n_clk_i) begin
    if (!kn_rst_n_reg) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg.rd <= k_rd_reg;
      cmd_reg.wr <= k_wr_reg;
      cmd_reg.rd_addr <= k_raddr_reg;
      cmd_reg.d0 <= k_d0_reg;
      cmd_reg.be0_n <= k_be0_n_reg;
      if (k_wr_reg) begin
        cmd_reg.wr_addr <= addr_i;
        cmd_reg.d1 <= data_i;
        cmd_reg.be1_n <= byte_write_sel_n_i;
      end
    end
  end

  always_ff @(posedge k_n_clk_i) begin
    if (!kn_rst_n_reg) begin
      cmd_ready_o <= ssd_pkg::RST_LOW;
    end else begin
      cmd_ready_o <= cmd_wready;
    end
  end

  logic [RD_W-1:0] rdf_wdata;
  logic rdf_wready, rdf_wvalid, rdf_rvalid;
  logic [RD_W-1:0] rdf_rdata_raw;
  logic [CMD_W-1:0] cmd_rdata_raw;
  ssd_pkg::ssd_rdata_t rdf_word, rdf_rdata;

  ssd_async_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .wclk_i(k_n_clk_i),
    .wrst_n_i(kn_rst_n_reg),
    .wvalid_i(cmd_valid_reg),
    .wdata_i(cmd_reg),
    .wready_o(cmd_wready),
    .rclk_i(clk_i),
    .rrst_n_i(resetn_i),
    .rvalid_o(cmd_rvalid),
    .rdata_o(cmd_rdata_raw),
    .rready_i(cmd_pop)
  );

  assign cmd_out = ssd_pkg::ssd_cmd_t'(cmd_rdata_raw);

  // Core: two arrays, one per burst word; a read stalls while the return FIFO is full
  logic [DW-1:0] arr0_reg [2**MEM_AW];
  logic [DW-1:0] arr1_reg [2**MEM_AW];
  logic [MEM_AW-1:0] rd_idx, wr_idx;

  assign rd_idx = cmd_out.rd_addr[MEM_AW-1:0];
  assign wr_idx = cmd_out.wr_addr[MEM_AW-1:0];
  assign cmd_pop = cmd_rvalid && (rdf_wready || !cmd_out.rd);
  assign rdf_wvalid = cmd_pop && cmd_out.rd;
  assign rdf_word.q0 = arr0_reg[rd_idx];
  assign rdf_word.q1 = arr1_reg[rd_idx];
  assign rdf_wdata = rdf_word;

  // Read sees the array before this access's own write, as on the pins
  always_ff @(posedge clk_i) begin
    if (cmd_pop && cmd_out.wr) begin
      for (int b = 0; b < NB; b++) begin
        if (!cmd_out.be0_n[b]) begin
          arr0_reg[wr_idx][b*BW +: BW] <= cmd_out.d0[b*BW +: BW];
        end
        if (!cmd_out.be1_n[b]) begin
          arr1_reg[wr_idx][b*BW +: BW] <= cmd_out.d1[b*BW +: BW];
        end
      end
    end
  end

  ssd_async_fifo #(
    .WIDTH(RD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .wclk_i(clk_i),
    .wrst_n_i(resetn_i),
    .wvalid_i(rdf_wvalid),
    .wdata_i(rdf_wdata),
    .wready_o(rdf_wready),
    .rclk_i(c_clk_i),
    .rrst_n_i(c_rst_n_reg),
    .rvalid_o(rdf_rvalid),
    .rdata_o(rdf_rdata_raw),
    .rready_i(1'b1)
  );

  assign rdf_rdata = ssd_pkg::ssd_rdata_t'(rdf_rdata_raw);

  // C rise: first beat out, or float once nothing is pending.
  // Single clock mode: the board feeds K and K# into the C and C# inputs.
  logic [DW-1:0] q_pos_reg, q1_hold_reg, q_neg_reg;
  logic drive_pos_reg, drive_neg_reg;
  logic echo_pos_tgl_reg, echo_neg_tgl_reg;
  logic phase_pos;

  always_ff @(posedge c_clk_i) begin
    if (!c_rst_n_reg) begin
      drive_pos_reg <= ssd_pkg::RST_LOW;
      q_pos_reg <= '0;
      q1_hold_reg <= '0;
    end else begin
      drive_pos_reg <= rdf_rvalid;
      if (rdf_rvalid) begin
        q_pos_reg <= rdf_rdata.q0;
        q1_hold_reg <= rdf_rdata.q1;
      end
    end
  end

  // C# rise: second beat of the same burst
  always_ff @(posedge c_n_clk_i) begin
    if (!cn_rst_n_reg) begin
      drive_neg_reg <= ssd_pkg::RST_LOW;
      q_neg_reg <= '0;
    end else begin
      drive_neg_reg <= drive_pos_reg;
      q_neg_reg <= q1_hold_reg;
    end
  end

  // Echo clocks: C toggles, C# copies, so the pair differs only in the C half
  // whichever domain leaves reset first
  always_ff @(posedge c_clk_i) begin
    if (!c_rst_n_reg) begin
      echo_pos_tgl_reg <= ssd_pkg::RST_LOW;
    end else begin
      echo_pos_tgl_reg <= !echo_pos_tgl_reg;
    end
  end

  always_ff @(posedge c_n_clk_i) begin
    if (!cn_rst_n_reg) begin
      echo_neg_tgl_reg <= ssd_pkg::RST_LOW;
    end else begin
      echo_neg_tgl_reg <= echo_pos_tgl_reg;
    end
  end

  assign phase_pos = echo_pos_tgl_reg ^ echo_neg_tgl_reg;
  assign echo_clock_pos_o = phase_pos;
  assign echo_clock_neg_o = !phase_pos;
  assign q_o = phase_pos ? q_pos_reg : q_neg_reg;
  assign q_oe_n_o = phase_pos ? !drive_pos_reg : !drive_neg_reg;

endmodule

`default_nettype wire

// ### ssd_pkg.sv
package ssd_pkg;

  // Word layout for the 36-bit configuration: four 9-bit byte lanes
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = DATA_W / BYTE_W;

  // Address width per configuration: 23 for x9, 22 for x18, 21 for x36
  localparam int ADDR_W_X9 = 23;
  localparam int ADDR_W_X18 = 22;
  localparam int ADDR_W_X36 = 21;
  localparam int ADDR_W = ADDR_W_X36;

  // Row index bits per internal array in this model (array index = low address bits)
  localparam int MEM_AW = 4;

  // Depth of each clock-crossing FIFO
  localparam int FIFO_DEPTH = 4;

  // Reset values
  localparam logic RST_LOW = 1'b0;
  localparam logic RST_HIGH = 1'b1;

  // One access as captured at the pins: selects, read address and first write beat on K, write address and second beat on K#
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] rd_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] d0;
    logic [DATA_W-1:0] d1;
    logic [NUM_BYTES-1:0] be0_n;
    logic [NUM_BYTES-1:0] be1_n;
  } ssd_cmd_t;

  // Two-word read burst
  typedef struct packed {
    logic [DATA_W-1:0] q0;
    logic [DATA_W-1:0] q1;
  } ssd_rdata_t;

endpackage

// ### ssd_async_fifo.sv
`timescale 1ns/10ps
`default_nettype none

// Dual-clock FIFO with gray-coded pointers crossing through two flip-flops
module ssd_async_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic wclk_i,
  input wire logic wrst_n_i,
  input wire logic wvalid_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic wready_o,
  input wire logic rclk_i,
  input wire logic rrst_n_i,
  output logic rvalid_o,
  output logic [WIDTH-1:0] rdata_o,
  input wire logic rready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0] rgray_s1_reg, rgray_s2_reg, wgray_s1_reg, wgray_s2_reg;
  logic [AW:0] wbin_next, rbin_next;
  logic full, empty;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    to_gray = b ^ (b >> 1);
  endfunction

  // Full when write pointer is one lap ahead of the synchronised read pointer
  assign full = (wgray_reg == {~rgray_s2_reg[AW -: 2], rgray_s2_reg[AW-2:0]});
  assign empty = (rgray_reg == wgray_s2_reg);
  assign wready_o = ~full;
  assign rvalid_o = ~empty;
  assign rdata_o = mem_reg[rbin_reg[AW-1:0]];
  assign wbin_next = wbin_reg + (AW+1)'(wvalid_i && !full);
  assign rbin_next = rbin_reg + (AW+1)'(rready_i && !empty);

  always_ff @(posedge wclk_i) begin
    if (wvalid_i && !full) begin
      mem_reg[wbin_reg[AW-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge wclk_i) begin
    if (!wrst_n_i) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
      rgray_s1_reg <= '0;
      rgray_s2_reg <= '0;
    end else begin
      wbin_reg <= wbin_next;
      wgray_reg <= to_gray(wbin_next);
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
    end
  end

  always_ff @(posedge rclk_i) begin
    if (!rrst_n_i) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
      wgray_s1_reg <= '0;
      wgray_s2_reg <= '0;
    end else begin
      rbin_reg <= rbin_next;
      rgray_reg <= to_gray(rbin_next);
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
    end
  end

endmodule

`default_nettype wire

// ### ssd_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ssd_chk #(
  parameter int MEM_AW = 4,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic k_clk_i,
  input wire logic c_clk_i,
  input wire logic c_n_clk_i,
  input wire logic read_port_sel_n_i,
  input wire logic [ssd_pkg::DATA_W-1:0] q_o,
  input wire logic q_oe_n_o,
  input wire logic echo_clock_pos_o,
  input wire logic echo_clock_neg_o,
  input wire logic cmd_ready_o
);
  // Output clock edges seen since reset release, and during reset
  logic [3:0] run_reg = 4'h0;
  logic [3:0] rst_reg = 4'h0;
  always_ff @(posedge c_clk_i) begin
    if (!resetn_i) run_reg <= 4'h0;
    else if (run_reg != 4'hf) run_reg <= run_reg + 4'h1;
  end
  always_ff @(posedge c_clk_i) begin
    if (resetn_i) rst_reg <= 4'h0;
    else if (rst_reg != 4'hf) rst_reg <= rst_reg + 4'h1;
  end
  rst_float_a: assert property (@(posedge c_clk_i) rst_reg > 4'h5 |-> q_oe_n_o)
    else $error("read data driven in reset");
  rst_echo_a: assert property (@(posedge c_clk_i) rst_reg > 4'h5 |-> !echo_clock_pos_o)
    else $error("echo clock running in reset");
  rst_ready_a: assert property (@(posedge c_clk_i) rst_reg > 4'h5 |-> !cmd_ready_o)
    else $error("command path ready in reset");
  echo_low_a: assert property (@(posedge c_clk_i) disable iff (!resetn_i)
    run_reg > 4'h8 |-> !echo_clock_pos_o) else $error("echo high before C rise");
  echo_high_a: assert property (@(posedge c_n_clk_i) disable iff (!resetn_i)
    run_reg > 4'h8 |-> echo_clock_pos_o) else $error("echo low before C# rise");
  echo_pair_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    run_reg > 4'h8 |-> echo_clock_neg_o != echo_clock_pos_o) else $error("echo pair equal");
  idle_float_a: assert property (@(posedge c_clk_i) disable iff (!resetn_i)
    read_port_sel_n_i [*8] |-> q_oe_n_o) else $error("outputs driven while deselected");
  burst_two_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(q_oe_n_o) |-> (!q_oe_n_o) [*3]) else $error("burst shorter than two beats");
  beat_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !q_oe_n_o && $past(!q_oe_n_o) && $stable(echo_clock_pos_o) |-> $stable(q_o))
    else $error("read beat changed between output clock edges");
  ready_run_a: assert property (@(posedge k_clk_i) disable iff (!resetn_i)
    run_reg > 4'h8 |-> cmd_ready_o) else $error("command path refused traffic");
  burst_c: cover property (@(posedge clk_i) $fell(q_oe_n_o));
  idle_c: cover property (@(posedge c_clk_i) read_port_sel_n_i [*8] ##1 q_oe_n_o);
  ready_c: cover property (@(posedge k_clk_i) $rose(cmd_ready_o));
endmodule
`default_nettype wire

// ### ssd_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssd_ctrl_model (
  output logic k_o,
  output logic kn_o,
  output logic read_port_sel_n_o,
  output logic write_port_sel_n_o,
  output logic [ssd_pkg::ADDR_W-1:0] addr_o,
  output logic [ssd_pkg::DATA_W-1:0] data_o,
  output logic [ssd_pkg::NUM_BYTES-1:0] byte_write_sel_n_o
);
  initial begin
    k_o = 1'b0;
    #3;
    forever #16 k_o = ~k_o;
  end
  assign kn_o = ~k_o;
  initial begin
    read_port_sel_n_o = 1'b1;
    write_port_sel_n_o = 1'b1;
    addr_o = '0;
    data_o = '0;
    byte_write_sel_n_o = '1;
  end
  // One K cycle: read address and beat one before K, write address and beat two before K#
  task automatic cyc(input logic rd, input logic wr, input logic [ssd_pkg::ADDR_W-1:0] ra,
    input logic [ssd_pkg::ADDR_W-1:0] wa, input ssd_pkg::ssd_rdata_t d, input logic [7:0] m);
    @(posedge kn_o);
    #8;
    read_port_sel_n_o = !rd;
    write_port_sel_n_o = !wr;
    addr_o = ra;
    data_o = d.q0;
    byte_write_sel_n_o = m[7:4];
    @(posedge k_o);
    #8;
    addr_o = wa;
    data_o = d.q1;
    byte_write_sel_n_o = m[3:0];
  endtask
  // Released lines flip once per K cycle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge kn_o);
      #8;
      read_port_sel_n_o = 1'b1;
      write_port_sel_n_o = 1'b1;
      addr_o = ~addr_o;
      data_o = ~data_o;
      byte_write_sel_n_o = ~byte_write_sel_n_o;
    end
  endtask
endmodule
`default_nettype wire

// ### ssd_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam ssd_pkg::ssd_rdata_t D1 = {36'h123456789, 36'h0abcdef01};
  localparam ssd_pkg::ssd_rdata_t M1 = {36'hffb47ff89, 36'h0a801ee00};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic k, kn, rd_sel_n, wr_sel_n, oe_n, ep, en, rdy;
  logic [ssd_pkg::ADDR_W-1:0] addr;
  logic [ssd_pkg::DATA_W-1:0] data;
  logic [ssd_pkg::DATA_W-1:0] q;
  logic [ssd_pkg::NUM_BYTES-1:0] bw_sel_n;
  ssd_pkg::ssd_rdata_t rq[$];
  ssd_pkg::ssd_rdata_t b;
  int miscompares = 0;
  int n_compared = 0;
  int ecnt = 0;
  initial forever #4 clk_i = ~clk_i;
  ssd_ctrl_model ctl (.k_o(k), .kn_o(kn), .read_port_sel_n_o(rd_sel_n),
    .write_port_sel_n_o(wr_sel_n), .addr_o(addr), .data_o(data), .byte_write_sel_n_o(bw_sel_n));
  ssd_sram_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .k_clk_i(k), .k_n_clk_i(kn),
    .c_clk_i(k), .c_n_clk_i(kn),
    .read_port_sel_n_i(rd_sel_n), .write_port_sel_n_i(wr_sel_n), .addr_i(addr), .data_i(data),
    .byte_write_sel_n_i(bw_sel_n), .q_o(q), .q_oe_n_o(oe_n), .echo_clock_pos_o(ep),
    .echo_clock_neg_o(en), .cmd_ready_o(rdy));
  // Read beats are taken mid half, away from the launching edges
  always @(posedge k) begin
    #8;
    if (oe_n === 1'b0) begin
      b.q0 = q;
      @(posedge kn);
      #8;
      b.q1 = q;
      rq.push_back(b);
    end
  end
  always @(posedge ep) ecnt++;
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic get(input ssd_pkg::ssd_rdata_t exp);
    int i;
    for (i = 0; i < 12 && rq.size() == 0; i++) ctl.idle(1);
    if (rq.size() == 0) begin
      miscompares++;
      finish_test();
    end else begin
      check(rq.pop_front(), exp);
    end
  endtask
  task automatic wr(input logic [20:0] a, input ssd_pkg::ssd_rdata_t d, input logic [7:0] m);
    ctl.cyc(1'b0, 1'b1, ~a, a, d, m);
    ctl.idle(2);
  endtask
  // Write select stays high here, so the enabled lanes and data must be ignored
  task automatic rd(input logic [20:0] a, input ssd_pkg::ssd_rdata_t exp);
    ctl.cyc(1'b1, 1'b0, a, ~a, ~exp, 8'h00);
    get(exp);
  endtask
  task automatic s_data;
    wr(21'h5, D1, 8'h00);
    rd(21'h5, D1);
    wr(21'h5, {36'hfffffffff, 36'h000000000}, 8'h5a);
    rd(21'h5, M1);
  endtask
  task automatic s_desel;
    ctl.cyc(1'b0, 1'b0, 21'h5, 21'h5, 72'h0, 8'h00);
    ctl.idle(8);
    check(rq.size(), 0);
    rd(21'h5, M1);
  endtask
  task automatic s_b2b;
    wr(21'h7, D1, 8'h00);
    ctl.cyc(1'b1, 1'b0, 21'h5, 21'h0, ~D1, 8'hff);
    ctl.cyc(1'b1, 1'b1, 21'h7, 21'h7, ~D1, 8'h00);
    get(M1);
    get(D1);
    rd(21'h7, ~D1);
  endtask
  task automatic s_echo;
    int e0;
    e0 = ecnt;
    ctl.idle(8);
    check(ecnt - e0, 8);
  endtask
  // Mid-run reset: outputs float and echo clocks stop; memory keeps its contents
  task automatic s_reset;
    @(negedge clk_i);
    resetn_i = 1'b0;
    ctl.idle(8);
    check({oe_n, ep, en, rdy}, 4'ha);
    @(negedge clk_i);
    resetn_i = 1'b1;
    ctl.idle(6);
    rd(21'h7, ~D1);
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    ctl.idle(6);
    s_data();
    s_desel();
    s_b2b();
    s_echo();
    s_reset();
    finish_test();
  end
endmodule
bind ssd_sram_port ssd_chk #(.MEM_AW(MEM_AW), .FIFO_DEPTH(FIFO_DEPTH)) chk (.clk_i, .resetn_i,
  .k_clk_i, .c_clk_i, .c_n_clk_i, .read_port_sel_n_i, .q_o, .q_oe_n_o, .echo_clock_pos_o,
  .echo_clock_neg_o, .cmd_ready_o);
`default_nettype wire
